//--- rec_fifo.sv
// record fifo with registered read side
module rec_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // fill side
    rec_stream_if.snk             wr,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_q < (PW+1)'(DEPTH));
    assign wr.level = 5'(cnt_q);
    assign push     = wr.valid && wr.ready;
    // refill the output stage whenever it is free or being taken
    assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data  <= mem_q[rd_ptr_q];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end
endmodule // rec_fifo

//--- rec_sink_model.sv
// record consumer: random back-pressure, forms interval results
module rec_sink_model
#(
    parameter longint OFFSET_PS = 500,
    parameter longint EV_OVF    = 65536,
    parameter longint TIME_OVF  = 4194304
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // record stream
    input  wire logic        rec_valid,
    input  wire logic [63:0] rec_data,
    input  wire logic        dual,
    input  wire logic        stall,
    output logic             rec_ready,
    // latest interval result and missed event count
    output longint           interval_ps,
    output longint           missed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] lfsr_q;
    logic        second_q;
    logic        slot;
    logic [15:0] ev_raw;
    logic [15:0] ev_prev_q [2];
    logic [21:0] t_prev_q;
    longint      ev_base_q [2];
    longint      ev_corr;
    longint      t_base_q;
    longint      t_corr;
    longint      start_q;
    longint      stamp;
    // bench counts are random, so the results are indicative only
    // two-channel start and stop counts unwind apart, single-channel as one run
    assign slot    = dual && second_q;
    assign ev_raw  = second_q ? rec_data[63:48] : (rec_data[63:48] | rec_data[47:32]);
    assign ev_corr = ev_base_q[slot] + longint'(ev_raw) + ((ev_raw < ev_prev_q[slot]) ? EV_OVF : 0);
    assign t_corr  = t_base_q + longint'(rec_data[31:10]) + ((rec_data[31:10] < t_prev_q) ? TIME_OVF : 0);
    // unwrapped count first, then fine count and offset
    assign stamp   = t_corr * 2000 - longint'(rec_data[9:2]) * 100;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            lfsr_q    <= 32'h0BB00187;
            rec_ready <= 1'b0;
        end
        else
        begin
            lfsr_q    <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
            rec_ready <= !stall && lfsr_q[1:0] != 2'h0;
        end
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            second_q    <= 1'b0;
            start_q     <= 0;
            interval_ps <= 0;
            missed      <= 0;
            t_base_q    <= 0;
            t_prev_q    <= 22'h000000;
            ev_base_q   <= '{0, 0};
            ev_prev_q   <= '{16'h0000, 16'h0000};
        end
        else if (rec_valid && rec_ready)
        begin
            second_q        <= !second_q;
            t_base_q        <= t_corr - longint'(rec_data[31:10]);
            t_prev_q        <= rec_data[31:10];
            ev_base_q[slot] <= ev_corr - longint'(ev_raw);
            ev_prev_q[slot] <= ev_raw;
            // single-channel: next start against this stop; two-channel: per channel
            if (dual)
                missed <= ev_corr - ev_base_q[slot] - longint'(ev_prev_q[slot]) - 1;
            else if (!second_q)
                missed <= ev_corr - ev_base_q[slot] - longint'(ev_prev_q[slot]) - 1;
            if (!second_q)
                start_q <= stamp;
            else
                interval_ps <= stamp + OFFSET_PS - start_q;
        end
endmodule // rec_sink_model

//--- rec_stream_if.sv
// record stream between the pairing logic and the record fifo
interface rec_stream_if;
    logic        valid;
    logic        ready;
    logic [63:0] data;
    logic [4:0]  level;

    modport src
    (
        output valid,
        output data,
        input  ready,
        input  level
    );
    modport snk
    (
        input  valid,
        input  data,
        output ready,
        output level
    );
endinterface

//--- tirp_pkg.sv
// types shared by the record processor modules
package tirp_pkg;
    typedef enum logic [1:0] {
        ST_WAIT_START = 2'b00,
        ST_WAIT_STOP  = 2'b01,
        ST_EMIT_START = 2'b10,
        ST_EMIT_STOP  = 2'b11
    } pair_state_e;

    typedef enum logic [3:0] {
        ARM_AUTOMATIC     = 4'h0,
        ARM_EDGE_HOLDOFF  = 4'h1,
        ARM_INTERVAL_SMP  = 4'h2,
        ARM_RANDOM_SMP    = 4'h3,
        ARM_EDGE_INTERVAL = 4'h4,
        ARM_EDGE_RANDOM   = 4'h5,
        ARM_REP_EDGE      = 4'h6,
        ARM_TIME_HOLDOFF  = 4'h7,
        ARM_EVENT_HOLDOFF = 4'h8
    } arm_mode_e;

    typedef enum logic {
        FMT_SINGLE = 1'b0,
        FMT_DUAL   = 1'b1
    } rec_fmt_e;
endpackage

//--- tirp_regs.svh
// register offsets, record field layout and fixed sizes for the record processor
`ifndef TIRP_REGS_SVH
`define TIRP_REGS_SVH

`define TIRP_ADDR_W          8
`define TIRP_OFF_CTRL        8'h00
`define TIRP_OFF_STATUS      8'h04
`define TIRP_OFF_MEAS_CNT    8'h08
`define TIRP_OFF_DROP_CNT    8'h0C

`define TIRP_CTRL_EN_BIT     0
`define TIRP_CTRL_FMT_BIT    1
`define TIRP_CTRL_CHAN_BIT   2
`define TIRP_CTRL_ARM_LSB    4
`define TIRP_CTRL_ARM_MSB    7
`define TIRP_CTRL_RESET      32'h00000000
`define TIRP_CTRL_MASK       32'h000000F7

`define TIRP_EV_W            16
`define TIRP_TIME_W          22
`define TIRP_INT_W           8
`define TIRP_REC_W           64
`define TIRP_FIFO_DEPTH      16
`define TIRP_LVL_W           5

`define TIRP_REC_F0_MSB      63
`define TIRP_REC_F0_LSB      48
`define TIRP_REC_F1_MSB      47
`define TIRP_REC_F1_LSB      32
`define TIRP_REC_TIME_MSB    31
`define TIRP_REC_TIME_LSB    10
`define TIRP_REC_INT_MSB     9
`define TIRP_REC_INT_LSB     2
`define TIRP_REC_BS_BIT      1
`define TIRP_REC_INH_BIT     0
`define TIRP_UNUSED_FIELD    16'h0000

`endif

//--- tirp_top.sv
// time interval record formatter: pairs samples and emits binary records
// Function
// RULE1 - Each measurement is emitted as exactly two records, the start record followed by its stop record.
// RULE2 - The single-channel record carries event count, unused field, coarse time, fine count, group-begin and inhibit.
// RULE3 - The two-channel start record holds unused field then start-channel events, the stop record stop-channel events then unused field.
// RULE4 - The two-channel layout is produced under automatic, edge holdoff, interval, random, edge/interval, edge/random and repetitive edge arming.
// RULE5 - The consumer adds the event overflow correction to every event count from the first one smaller than its predecessor onward.
// RULE6 - The consumer adds the time overflow correction to every coarse time count from the first one smaller than its predecessor onward.
// RULE7 - The consumer forms a time stamp as corrected coarse count times 2 ns minus fine count times 0.1 ns.
// RULE8 - The consumer adds a setup path offset to every stop time stamp and leaves start stamps alone.
// RULE9 - The consumer takes the interval as corrected stop stamp minus start stamp of the same measurement.
// RULE10 - For the preceding format the consumer counts missed stop events as next stop stamp minus this stop stamp minus 1.
// RULE11 - In single-channel form the consumer counts missed events as next start stamp minus this stop stamp minus 1.
// RULE12 - In two-channel form the consumer counts missed start events as start events between successive starts minus 1.
// RULE13 - In two-channel form the consumer counts missed stop events as stop events between successive stops minus 1.
// RULE14 - The consumer learns which input supplies start and which supplies stop before reading two-channel records.
// RULE15 - The consumer unwinds rollovers before merging fine counts or adding the path offset.
`include "tirp_regs.svh"

module tirp_top
    import tirp_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // register port
    input  wire logic [`TIRP_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    // sample capture
    input  wire logic                    smp_valid,
    input  wire logic                    smp_is_stop,
    input  wire logic [`TIRP_EV_W-1:0]   smp_ev_a,
    input  wire logic [`TIRP_EV_W-1:0]   smp_ev_b,
    input  wire logic [`TIRP_TIME_W-1:0] smp_time,
    input  wire logic [`TIRP_INT_W-1:0]  smp_int,
    input  wire logic                    smp_block_start,
    input  wire logic                    smp_inhibit,
    output logic                         smp_ready,
    // record stream out
    output logic                         rec_valid,
    input  wire logic                    rec_ready,
    output logic [`TIRP_REC_W-1:0]       rec_data
);
    rec_stream_if push_if ();

    logic [31:0]            ctrl_q;
    logic [31:0]            meas_cnt_q;
    logic [31:0]            drop_cnt_q;
    pair_state_e            state_q;
    pair_state_e            state_d;
    logic [`TIRP_REC_W-1:0] start_rec_q;
    logic [`TIRP_REC_W-1:0] stop_rec_q;
    logic [`TIRP_REC_W-1:0] smp_rec;
    logic                   en;
    rec_fmt_e               fmt;
    logic                   start_on_b;
    arm_mode_e              arm;
    logic                   cfg_ok;
    logic                   take;
    logic                   pushed;
    logic [`TIRP_EV_W-1:0]  ev_start;
    logic [`TIRP_EV_W-1:0]  ev_stop;

    assign en         = ctrl_q[`TIRP_CTRL_EN_BIT];
    assign fmt        = rec_fmt_e'(ctrl_q[`TIRP_CTRL_FMT_BIT]);
    assign start_on_b = ctrl_q[`TIRP_CTRL_CHAN_BIT];
    assign arm        = arm_mode_e'(ctrl_q[`TIRP_CTRL_ARM_MSB:`TIRP_CTRL_ARM_LSB]);

    // the chosen layout must match the arming mode, otherwise nothing is taken
    always_comb
    begin
        cfg_ok = 1'b0;
        if (fmt == FMT_DUAL)
        begin
            cfg_ok = (arm inside {ARM_AUTOMATIC, ARM_EDGE_HOLDOFF, ARM_INTERVAL_SMP, ARM_RANDOM_SMP,
                                  ARM_EDGE_INTERVAL, ARM_EDGE_RANDOM, ARM_REP_EDGE}); // RULE4
        end
        else
        begin
            cfg_ok = (arm inside {ARM_TIME_HOLDOFF, ARM_EVENT_HOLDOFF});
        end
    end

    // channel mapping decides which counter feeds the start and stop slots
    assign ev_start = start_on_b ? smp_ev_b : smp_ev_a; // RULE14
    assign ev_stop  = start_on_b ? smp_ev_a : smp_ev_b;

    always_comb
    begin
        smp_rec = '0;
        smp_rec[`TIRP_REC_TIME_MSB:`TIRP_REC_TIME_LSB] = smp_time;
        smp_rec[`TIRP_REC_INT_MSB:`TIRP_REC_INT_LSB]   = smp_int;
        smp_rec[`TIRP_REC_BS_BIT]                      = smp_block_start;
        smp_rec[`TIRP_REC_INH_BIT]                     = smp_inhibit;
        if (fmt == FMT_SINGLE)
        begin
            // single input: the measured channel's counter, then the unused field
            smp_rec[`TIRP_REC_F0_MSB:`TIRP_REC_F0_LSB] = ev_start; // RULE2
            smp_rec[`TIRP_REC_F1_MSB:`TIRP_REC_F1_LSB] = `TIRP_UNUSED_FIELD;
        end
        else if (!smp_is_stop)
        begin
            smp_rec[`TIRP_REC_F0_MSB:`TIRP_REC_F0_LSB] = `TIRP_UNUSED_FIELD; // RULE3
            smp_rec[`TIRP_REC_F1_MSB:`TIRP_REC_F1_LSB] = ev_start;
        end
        else
        begin
            smp_rec[`TIRP_REC_F0_MSB:`TIRP_REC_F0_LSB] = ev_stop; // RULE3
            smp_rec[`TIRP_REC_F1_MSB:`TIRP_REC_F1_LSB] = `TIRP_UNUSED_FIELD;
        end
    end

    assign take   = smp_valid && smp_ready;
    assign pushed = push_if.valid && push_if.ready;

    // start is held back until its stop arrives, so a pair is never split
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT_START:
            begin
                if (take && !smp_is_stop)
                begin
                    state_d = ST_WAIT_STOP; // RULE1
                end
            end
            ST_WAIT_STOP:
            begin
                if (take && smp_is_stop)
                begin
                    state_d = ST_EMIT_START; // RULE1
                end
            end
            ST_EMIT_START:
            begin
                if (pushed)
                begin
                    state_d = ST_EMIT_STOP;
                end
            end
            ST_EMIT_STOP:
            begin
                if (pushed)
                begin
                    state_d = ST_WAIT_START;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_WAIT_START;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            start_rec_q <= '0;
            stop_rec_q  <= '0;
        end
        else if (take)
        begin
            // a later start replaces an unmatched one
            if (!smp_is_stop)
            begin
                start_rec_q <= smp_rec;
            end
            else if (state_q == ST_WAIT_STOP)
            begin
                stop_rec_q <= smp_rec;
            end
        end
    end

    // leaves room for both records of a pair before taking a start; a push landing now counts too
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            smp_ready <= 1'b0;
        end
        else
        begin
            smp_ready <= en && cfg_ok && (state_d inside {ST_WAIT_START, ST_WAIT_STOP})
                         && ((push_if.level + 5'(pushed)) <= 5'(`TIRP_FIFO_DEPTH - 2));
        end
    end

    assign push_if.valid = (state_q == ST_EMIT_START) || (state_q == ST_EMIT_STOP);
    assign push_if.data  = (state_q == ST_EMIT_STOP) ? stop_rec_q : start_rec_q; // RULE1

    rec_fifo #(
        .WIDTH (`TIRP_REC_W),
        .DEPTH (`TIRP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr        (push_if.snk),
        .out_valid (rec_valid),
        .out_ready (rec_ready),
        .out_data  (rec_data)
    );

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meas_cnt_q <= '0;
            drop_cnt_q <= '0;
        end
        else
        begin
            if (pushed && state_q == ST_EMIT_STOP)
            begin
                meas_cnt_q <= meas_cnt_q + 32'h00000001;
            end
            // stop without start, or a start that overwrites a held one
            if (take && ((smp_is_stop && state_q == ST_WAIT_START) || (!smp_is_stop && state_q == ST_WAIT_STOP)))
            begin
                drop_cnt_q <= drop_cnt_q + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `TIRP_CTRL_RESET;
        end
        else if (reg_wr && reg_addr == `TIRP_OFF_CTRL)
        begin
            ctrl_q <= reg_wdata & `TIRP_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `TIRP_OFF_CTRL:     reg_rdata <= ctrl_q;
                `TIRP_OFF_STATUS:   reg_rdata <= {23'h000000, push_if.level, cfg_ok, start_on_b, 2'(state_q)};
                `TIRP_OFF_MEAS_CNT: reg_rdata <= meas_cnt_q;
                `TIRP_OFF_DROP_CNT: reg_rdata <= drop_cnt_q;
                default:            reg_rdata <= '0;
            endcase
        end
        else
        begin
            reg_rdata <= '0;
        end
    end
endmodule // tirp_top

//--- tirp_top_monitor.sv
// concurrent checks on the record processor top ports
`include "tirp_regs.svh"
module tirp_top_monitor
(
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst,
    // register port
    input wire logic [`TIRP_ADDR_W-1:0] reg_addr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    // sample and record streams
    input wire logic                    smp_valid,
    input wire logic                    smp_is_stop,
    input wire logic                    smp_ready,
    input wire logic                    rec_valid,
    input wire logic                    rec_ready,
    input wire logic [`TIRP_REC_W-1:0]  rec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       held_q;
    logic [5:0] occ_q;
    logic       take;
    assign take = smp_valid && smp_ready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            held_q <= 1'b0;
        else if (take)
            held_q <= !smp_is_stop;
    // counts records still owed, in flight or buffered
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            occ_q <= 6'h00;
        else
            occ_q <= occ_q + ((take && smp_is_stop && held_q) ? 6'h02 : 6'h00) - ((rec_valid && rec_ready) ? 6'h01 : 6'h00);
    a_rdata_idle_zero:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data not zero outside a read answer");
    a_unmapped_read_zero:
        assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h00000000)
        else $error("unmapped read returned data");
    a_rec_hold_stable:
        assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
        else $error("record changed or withdrawn before taken");
    a_stop_ready_gap:
        assert property (take && smp_is_stop && held_q |=> !smp_ready [*2])
        else $error("sample ready too soon after a pair completes");
    a_pair_emit_bound:
        assert property (take && smp_is_stop && held_q |-> ##[1:4] rec_valid)
        else $error("completed pair not emitted");
    a_rec_needs_data:
        assert property (occ_q == 6'h00 |-> !rec_valid)
        else $error("record offered without a completed pair");
    a_full_no_take:
        assert property (occ_q >= 6'h10 |-> !smp_ready)
        else $error("sample ready with full buffer");
    a_drop_no_record:
        assert property (take && smp_is_stop && !held_q && occ_q == 6'h00 |=> !rec_valid [*3])
        else $error("lone stop produced a record");
endmodule // tirp_top_monitor

//--- tirp_top_tb.sv
// self-checking bench for the time interval record processor
module tirp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h0BB00187;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, smp_valid = 1'b0, smp_is_stop = 1'b0;
    logic        smp_block_start = 1'b0, smp_inhibit = 1'b0, stall = 1'b0;
    logic [15:0] smp_ev_a = 16'h0, smp_ev_b = 16'h0;
    logic [21:0] smp_time = 22'h0;
    logic [7:0]  smp_int = 8'h00;
    logic        smp_ready, rec_valid, rec_ready, fmt_q = 1'b0, chan_q = 1'b0, ok, held = 1'b0;
    logic [63:0] rec_data, pend, expq[$];
    logic [31:0] bad[3] = '{32'h000000F7, 32'h00000073, 32'h00000001};
    int          n_mismatch = 0, samples_checked = 0, cyc = 0, drops = 0, pairs = 0, k;

    tirp_top tirp_top_i (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .smp_valid, .smp_is_stop,
        .smp_ev_a, .smp_ev_b, .smp_time, .smp_int, .smp_block_start, .smp_inhibit, .smp_ready, .rec_valid, .rec_ready,
        .rec_data);
    rec_sink_model rec_sink_model_i (.clk_sys, .rst, .rec_valid, .rec_data, .dual(fmt_q), .stall, .rec_ready,
        .interval_ps(), .missed());

    always #2 clk_sys = ~clk_sys;

    task automatic test_done();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
            fail(m);
    endtask
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // expected record for the sample now on the port
    function automatic logic [63:0] rec_of(input logic stop);
        logic [15:0] own;
        logic [15:0] far;
        logic [31:0] tail;
        own = chan_q ? smp_ev_b : smp_ev_a;
        far = chan_q ? smp_ev_a : smp_ev_b;
        tail = {smp_time, smp_int, smp_block_start, smp_inhibit};
        if (!fmt_q)
            return {own, 16'h0000, tail};
        return stop ? {far, 16'h0000, tail} : {16'h0000, own, tail};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        cmp(64'(reg_rdata), 64'(e), "register read");
    endtask
    task automatic cfg(input logic f, input logic c, input logic [3:0] arm);
        fmt_q  = f;
        chan_q = c;
        wr(8'h00, {24'h000000, arm, 1'b0, c, f, 1'b1});
    endtask
    // offer a sample and hold it until taken or lim cycles pass; fresh=0 keeps the held values
    task automatic send(input logic stop, input logic fresh, input int lim);
        logic [31:0] r;
        smp_valid   <= 1'b1;
        smp_is_stop <= stop;
        if (fresh)
        begin
            r = rnd();
            smp_ev_a <= r[15:0];
            smp_ev_b <= r[31:16];
            r = rnd();
            smp_time        <= r[21:0];
            smp_int         <= r[29:22];
            smp_block_start <= r[30];
            smp_inhibit     <= r[31];
        end
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++)
        begin
            @(posedge clk_sys);
            ok = smp_ready === 1'b1;
        end
        if (!ok && lim > 50)
            fail("sample not taken");
        if (ok && !stop)
        begin
            drops = drops + int'(held);
            held  = 1'b1;
            pend  = rec_of(1'b0);
        end
        if (ok && stop)
        begin
            if (held)
            begin
                expq.push_back(pend);
                expq.push_back(rec_of(1'b1));
                pairs++;
            end
            else
                drops++;
            held = 1'b0;
        end
    endtask
    task automatic pair();
        send(1'b0, 1'b1, 200);
        send(1'b1, 1'b1, 200);
    endtask
    task automatic idle();
        smp_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic drain();
        for (int n = 0; n < 500 && expq.size() != 0; n++)
            @(posedge clk_sys);
        if (expq.size() != 0)
            fail("records not delivered");
    endtask

    always @(posedge clk_sys)
        if (!rst && rec_valid === 1'b1 && rec_ready === 1'b1)
        begin
            if (expq.size() == 0)
                fail("record without a pair");
            else
                cmp(rec_data, expq.pop_front(), "record content");
        end

    // whole run needs a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail("timeout");
            test_done();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk_reg(8'h00, 32'h0);
        chk_reg(8'h0C, 32'h0);
        chk_reg(8'h10, 32'h0);
        wr(8'h00, 32'hFFFFFFFF);
        chk_reg(8'h00, 32'h000000F7);
        foreach (bad[i])
        begin
            wr(8'h00, bad[i]);
            repeat (3) @(posedge clk_sys);
            cmp(64'(smp_ready), 64'h0, "ready under illegal setup");
        end
        for (k = 7; k <= 8; k++)
        begin
            cfg(1'b0, k[0], k[3:0]);
            repeat (5) pair();
            idle();
        end
        for (k = 0; k <= 6; k++)
        begin
            cfg(1'b1, k[0], k[3:0]);
            repeat (3) pair();
            idle();
        end
        drain();
        send(1'b1, 1'b1, 200);
        send(1'b0, 1'b1, 200);
        pair();
        idle();
        drain();
        chk_reg(8'h0C, 32'(drops));
        chk_reg(8'h08, 32'(pairs));
        chk_reg(8'h04, {28'h0000000, 1'b1, chan_q, 2'h0});
        stall <= 1'b1;
        repeat (8) pair();
        send(1'b0, 1'b1, 30);
        cmp(64'(ok), 64'h0, "sample taken with full buffer");
        stall <= 1'b0;
        send(1'b0, 1'b0, 200);
        send(1'b1, 1'b1, 200);
        idle();
        drain();
        test_done();
    end
endmodule // tirp_top_tb

bind tirp_top tirp_top_monitor tirp_top_monitor_i (.clk_sys, .rst, .reg_addr, .reg_rd, .reg_rdata, .smp_valid,
    .smp_is_stop, .smp_ready, .rec_valid, .rec_ready, .rec_data);
